// >>> verilog/mag_irq_cfg.svh
`ifndef MAG_IRQ_CFG_SVH
`define MAG_IRQ_CFG_SVH

// Register addresses
`define ADDR_FILTER_OFFSET_CONFIG 7'h61
`define ADDR_INTERFACE_PIN_CONFIG 7'h62
`define ADDR_INTERRUPT_CONTROL    7'h63
`define ADDR_INTERRUPT_SOURCE     7'h64
`define ADDR_THRESHOLD_LOW        7'h65
`define ADDR_THRESHOLD_HIGH       7'h66

// Reset values
`define RST_FILTER_OFFSET_CONFIG  8'h00
`define RST_INTERFACE_PIN_CONFIG  8'h00
`define RST_INTERRUPT_CONTROL     8'hE0
`define RST_THRESHOLD             8'h00

// Write masks (must-be-zero bits stay zero)
`define WMASK_FILTER_OFFSET       8'h1F
`define WMASK_INTERFACE_PIN       8'h7B
`define WMASK_INTERRUPT_CONTROL   8'hE7

// filter_offset_config fields
`define B_LOWPASS                 0
`define B_OFFSET_CANCEL           1
`define B_SET_PULSE_RATE          2
`define B_IRQ_CORRECTED           3
`define B_SINGLE_OFFSET_CANCEL    4

// interface_pin_config fields
`define B_DRDY_TO_PIN             0
`define B_SELF_TEST               1
`define B_BYTE_SWAP               3
`define B_BLOCK_UPDATE            4
`define B_TWO_WIRE_DISABLE        5
`define B_IRQ_TO_PIN              6

// interrupt_control fields
`define B_IRQ_MASTER_EN           0
`define B_IRQ_LATCH               1
`define B_IRQ_ACTIVE_LEVEL        2
`define B_Z_IRQ_EN                5
`define B_Y_IRQ_EN                6
`define B_X_IRQ_EN                7

// Set pulse spacing in sample periods
`define SET_PULSE_PERIODS         6'd63

`endif

// >>> verilog/mag_irq_pkg.sv
package mag_irq_pkg;
  typedef enum logic [1:0] {
    RATE_10HZ,
    RATE_20HZ,
    RATE_50HZ,
    RATE_100HZ
  } sample_rate_t;

  typedef logic signed [15:0] axis_word_t;
endpackage : mag_irq_pkg

// >>> verilog/axis_threshold_check.sv
`timescale 1ns/100ps
`default_nettype none

module axis_threshold_check
  import mag_irq_pkg::*;
(
  // Sample in
  input  wire axis_word_t  raw_value,
  input  wire axis_word_t  hard_iron_offset,
  input  wire logic        use_corrected,
  input  wire logic        axis_en,
  input  wire logic [15:0] threshold,
  // Results
  output logic             above_pos,
  output logic             below_neg,
  output axis_word_t       corrected_value,
  output logic             overflow
);

  logic signed [16:0] sum_wide;
  logic signed [16:0] checked;
  logic signed [17:0] thr_ext;

  always_comb begin
    sum_wide        = 17'(raw_value) - 17'(hard_iron_offset);
    overflow        = sum_wide[16] != sum_wide[15];
    corrected_value = sum_wide[15:0];
    checked         = use_corrected ? sum_wide : 17'(raw_value);
    thr_ext         = {2'b00, threshold};
    above_pos       = axis_en && (18'(checked) > thr_ext);
    below_neg       = axis_en && (18'(checked) < -thr_ext);
  end

endmodule : axis_threshold_check

`default_nettype wire

// >>> verilog/mag_config_threshold_irq.sv
`timescale 1ns/100ps
`default_nettype none
`include "mag_irq_cfg.svh"

module mag_config_threshold_irq
  import mag_irq_pkg::*;
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  // Register port from the serial front end
  input  wire logic [6:0]   reg_addr,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_from_two_wire,
  output logic [7:0]        reg_rdata,
  // Output word read in progress (word being read by host)
  input  wire logic         out_word_read_busy,
  // Measurement path
  input  wire logic         sample_valid,
  input  wire sample_rate_t output_sample_rate,
  input  wire axis_word_t   x_raw,
  input  wire axis_word_t   y_raw,
  input  wire axis_word_t   z_raw,
  input  wire axis_word_t   x_hard_iron,
  input  wire axis_word_t   y_hard_iron,
  input  wire axis_word_t   z_hard_iron,
  input  wire logic         data_ready_clear,
  // Controls to the measurement path
  output logic              set_pulse,
  output logic              offset_cancel_en,
  output logic              single_meas_offset_cancel_en,
  output logic              lowpass_en,
  output logic [1:0]        filter_bw_div_log2,
  output logic              self_test_en,
  output logic              two_wire_disable,
  output logic              block_update_en,
  output logic              byte_swap_en,
  // Presented output words
  output logic [15:0]       x_out_word,
  output logic [15:0]       y_out_word,
  output logic [15:0]       z_out_word,
  output logic              all_axes_new_data,
  // Shared pin
  output logic              irq_ready_pin,
  output logic              irq_ready_pin_oe
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] filter_offset_config_reg;
  logic [7:0] interface_pin_config_reg;
  logic [7:0] interrupt_control_reg;
  logic [7:0] threshold_low_reg;
  logic [7:0] threshold_high_reg;
  logic [6:0] source_flags_reg;
  logic       irq_event_reg;
  logic       power_on_pulse_done_reg;
  logic [5:0] set_pulse_count_reg;
  logic       set_pulse_reg;
  logic       data_ready_reg;
  logic [15:0] x_out_reg;
  logic [15:0] y_out_reg;
  logic [15:0] z_out_reg;
  logic [7:0] rdata_reg;

  logic        access_ok;
  logic        wr_en;
  logic        rd_en;
  logic        source_read;
  logic [15:0] irq_threshold_value;
  logic [6:0]  source_flags_next;
  logic        crossing;
  logic        irq_master_en;
  logic        irq_latch_sel;
  logic        irq_active_level;
  logic        irq_on_corrected_data;
  logic        set_pulse_rate_sel;
  logic        data_ready_to_pin_en;
  logic        irq_to_pin_en;

  assign irq_master_en         = interrupt_control_reg[`B_IRQ_MASTER_EN];
  assign irq_latch_sel         = interrupt_control_reg[`B_IRQ_LATCH];
  assign irq_active_level      = interrupt_control_reg[`B_IRQ_ACTIVE_LEVEL];
  assign irq_on_corrected_data = filter_offset_config_reg[`B_IRQ_CORRECTED];
  assign set_pulse_rate_sel    = filter_offset_config_reg[`B_SET_PULSE_RATE];
  assign data_ready_to_pin_en  = interface_pin_config_reg[`B_DRDY_TO_PIN];
  assign irq_to_pin_en         = interface_pin_config_reg[`B_IRQ_TO_PIN];
  assign irq_threshold_value   = {threshold_high_reg, threshold_low_reg};

  // ----------------------------------------------------------------
  // Register access
  // ----------------------------------------------------------------
  assign access_ok   = !(reg_from_two_wire && two_wire_disable);
  assign wr_en       = reg_wr && access_ok;
  assign rd_en       = reg_rd && access_ok;
  assign source_read = rd_en && (reg_addr == `ADDR_INTERRUPT_SOURCE);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      filter_offset_config_reg <= `RST_FILTER_OFFSET_CONFIG;
      interface_pin_config_reg <= `RST_INTERFACE_PIN_CONFIG;
      interrupt_control_reg    <= `RST_INTERRUPT_CONTROL;
      threshold_low_reg        <= `RST_THRESHOLD;
      threshold_high_reg       <= `RST_THRESHOLD;
    end else if (wr_en) begin
      if (reg_addr == `ADDR_FILTER_OFFSET_CONFIG) begin
        filter_offset_config_reg <= reg_wdata & `WMASK_FILTER_OFFSET;
      end else if (reg_addr == `ADDR_INTERFACE_PIN_CONFIG) begin
        interface_pin_config_reg <=
          reg_wdata & `WMASK_INTERFACE_PIN;
      end else if (reg_addr == `ADDR_INTERRUPT_CONTROL) begin
        interrupt_control_reg <=
          reg_wdata & `WMASK_INTERRUPT_CONTROL;
      end else if (reg_addr == `ADDR_THRESHOLD_LOW) begin
        threshold_low_reg <= reg_wdata;
      end else if (reg_addr == `ADDR_THRESHOLD_HIGH) begin
        threshold_high_reg <= reg_wdata;
      end
    end
  end

  // Read data register, one cycle after the read strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (rd_en) begin
      if (reg_addr == `ADDR_FILTER_OFFSET_CONFIG) begin
        rdata_reg <= filter_offset_config_reg;
      end else if (reg_addr == `ADDR_INTERFACE_PIN_CONFIG) begin
        rdata_reg <= interface_pin_config_reg;
      end else if (reg_addr == `ADDR_INTERRUPT_CONTROL) begin
        rdata_reg <= interrupt_control_reg;
      end else if (reg_addr == `ADDR_INTERRUPT_SOURCE) begin
        rdata_reg <= {source_flags_reg, irq_event_reg ~^ irq_active_level};
      end else if (reg_addr == `ADDR_THRESHOLD_LOW) begin
        rdata_reg <= threshold_low_reg;
      end else if (reg_addr == `ADDR_THRESHOLD_HIGH) begin
        rdata_reg <= threshold_high_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  assign reg_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign offset_cancel_en             =
    filter_offset_config_reg[`B_OFFSET_CANCEL];
  assign single_meas_offset_cancel_en =
    filter_offset_config_reg[`B_SINGLE_OFFSET_CANCEL];
  assign lowpass_en                   = filter_offset_config_reg[`B_LOWPASS];
  assign filter_bw_div_log2           = lowpass_en ? 2'd2 : 2'd1;
  assign self_test_en     = interface_pin_config_reg[`B_SELF_TEST];
  assign two_wire_disable = interface_pin_config_reg[`B_TWO_WIRE_DISABLE];
  assign block_update_en  = interface_pin_config_reg[`B_BLOCK_UPDATE];
  assign byte_swap_en     = interface_pin_config_reg[`B_BYTE_SWAP];

  // ----------------------------------------------------------------
  // Set pulse sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      set_pulse_count_reg     <= 6'd0;
      power_on_pulse_done_reg <= 1'b0;
      set_pulse_reg           <= 1'b0;
    end else begin
      set_pulse_reg <= 1'b0;
      if (!power_on_pulse_done_reg) begin
        power_on_pulse_done_reg <= 1'b1;
        set_pulse_reg           <= 1'b1;
      end else if (sample_valid && !set_pulse_rate_sel) begin
        if (set_pulse_count_reg == `SET_PULSE_PERIODS - 6'd1) begin
          set_pulse_count_reg <= 6'd0;
          set_pulse_reg       <= 1'b1;
        end else begin
          set_pulse_count_reg <= set_pulse_count_reg + 6'd1;
        end
      end
    end
  end

  assign set_pulse = set_pulse_reg;

  // ----------------------------------------------------------------
  // Axis checks
  // ----------------------------------------------------------------
  logic [2:0] pos_hit;
  logic [2:0] neg_hit;
  logic [2:0] ovf_hit;
  axis_word_t corr_x;
  axis_word_t corr_y;
  axis_word_t corr_z;

  axis_threshold_check u_check_x (
    .raw_value        (x_raw),
    .hard_iron_offset (x_hard_iron),
    .use_corrected    (irq_on_corrected_data),
    .axis_en          (interrupt_control_reg[`B_X_IRQ_EN]),
    .threshold        (irq_threshold_value),
    .above_pos        (pos_hit[2]),
    .below_neg        (neg_hit[2]),
    .corrected_value  (corr_x),
    .overflow         (ovf_hit[2])
  );

  axis_threshold_check u_check_y (
    .raw_value        (y_raw),
    .hard_iron_offset (y_hard_iron),
    .use_corrected    (irq_on_corrected_data),
    .axis_en          (interrupt_control_reg[`B_Y_IRQ_EN]),
    .threshold        (irq_threshold_value),
    .above_pos        (pos_hit[1]),
    .below_neg        (neg_hit[1]),
    .corrected_value  (corr_y),
    .overflow         (ovf_hit[1])
  );

  axis_threshold_check u_check_z (
    .raw_value        (z_raw),
    .hard_iron_offset (z_hard_iron),
    .use_corrected    (irq_on_corrected_data),
    .axis_en          (interrupt_control_reg[`B_Z_IRQ_EN]),
    .threshold        (irq_threshold_value),
    .above_pos        (pos_hit[0]),
    .below_neg        (neg_hit[0]),
    .corrected_value  (corr_z),
    .overflow         (ovf_hit[0])
  );

  // ----------------------------------------------------------------
  // Interrupt source and flag
  // ----------------------------------------------------------------
  assign crossing = irq_master_en && ((|pos_hit) || (|neg_hit));

  always_comb begin
    source_flags_next = source_flags_reg;
    if (sample_valid) begin
      if (irq_latch_sel) begin
        if (source_read) begin
          source_flags_next = 7'h00;
        end
        if (irq_master_en) begin
          source_flags_next[6:1] = source_flags_next[6:1] |
                                   {pos_hit, neg_hit};
        end
      end else begin
        source_flags_next[6:1] = irq_master_en ? {pos_hit, neg_hit} : 6'h00;
      end
      // Overflow is always tracked, set wins over read clear
      source_flags_next[0] = source_flags_reg[0] & ~source_read;
      source_flags_next[0] = source_flags_next[0] | (|ovf_hit);
    end else if (source_read) begin
      source_flags_next[0] = 1'b0;
      if (irq_latch_sel) begin
        source_flags_next = 7'h00;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      source_flags_reg <= 7'h00;
    end else begin
      source_flags_reg <= source_flags_next;
    end
  end

  // Pulsed: active for one sample period; latched: held until read
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_event_reg <= 1'b0;
    end else if (sample_valid) begin
      if (irq_latch_sel) begin
        irq_event_reg <= crossing | (irq_event_reg & ~source_read);
      end else begin
        irq_event_reg <= crossing;
      end
    end else if (source_read && irq_latch_sel) begin
      irq_event_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Output words and data ready
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      x_out_reg <= 16'h0000;
      y_out_reg <= 16'h0000;
      z_out_reg <= 16'h0000;
    end else if (sample_valid && !(block_update_en & out_word_read_busy)) begin
      x_out_reg <= corr_x;
      y_out_reg <= corr_y;
      z_out_reg <= corr_z;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_ready_reg <= 1'b0;
    end else if (sample_valid) begin
      data_ready_reg <= 1'b1;
    end else if (data_ready_clear) begin
      data_ready_reg <= 1'b0;
    end
  end

  assign x_out_word = byte_swap_en ? {x_out_reg[7:0], x_out_reg[15:8]}
                                   : x_out_reg;
  assign y_out_word = byte_swap_en ? {y_out_reg[7:0], y_out_reg[15:8]}
                                   : y_out_reg;
  assign z_out_word = byte_swap_en ? {z_out_reg[7:0], z_out_reg[15:8]}
                                   : z_out_reg;
  assign all_axes_new_data = data_ready_reg;

  // ----------------------------------------------------------------
  // Shared pin
  // ----------------------------------------------------------------
  logic pin_active;

  always_comb begin
    pin_active = (irq_to_pin_en && irq_event_reg) ||
                 (data_ready_to_pin_en && data_ready_reg);
  end

  assign irq_ready_pin_oe = irq_to_pin_en || data_ready_to_pin_en;
  assign irq_ready_pin    = (irq_to_pin_en && !data_ready_to_pin_en) ?
                            (irq_event_reg ~^ irq_active_level)
                            : pin_active;

endmodule : mag_config_threshold_irq

`default_nettype wire

// >>> tb/mag_irq_props.sv
`timescale 1ns/100ps
`default_nettype none

module mag_irq_props (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       reset_n,
  // Register port
  input wire logic [6:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_from_two_wire,
  input wire logic [7:0] reg_rdata,
  // Watched outputs
  input wire logic       sample_valid,
  input wire logic       set_pulse,
  input wire logic       offset_cancel_en,
  input wire logic       lowpass_en,
  input wire logic [1:0] filter_bw_div_log2,
  input wire logic       two_wire_disable,
  input wire logic       byte_swap_en,
  input wire logic       irq_ready_pin_oe
);
  logic acc;

  assign acc = !(reg_from_two_wire && two_wire_disable);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------
  // Access steps
  // ----------------------------------------
  sequence wr_to(logic [6:0] a);
    reg_wr && acc && reg_addr == a;
  endsequence
  sequence rd_of(logic [6:0] a);
    reg_rd && !reg_wr && acc && reg_addr == a && !sample_valid;
  endsequence

  chk_bw_select: assert property (
    filter_bw_div_log2 == (lowpass_en ? 2'h2 : 2'h1))
    else $error("filter bandwidth code wrong");
  chk_offset_write: assert property (
    wr_to(7'h61) |=> offset_cancel_en == $past(reg_wdata[1]))
    else $error("offset cancel bit not taken");
  chk_two_wire_ignore: assert property (
    reg_wr && !acc && reg_addr == 7'h61 |=> $stable(lowpass_en))
    else $error("write over disabled two-wire taken");
  chk_swap_write: assert property (
    wr_to(7'h62) |=> byte_swap_en == $past(reg_wdata[3])
      && two_wire_disable == $past(reg_wdata[5]))
    else $error("pin config bits not taken");
  chk_pin_enable: assert property (
    wr_to(7'h62) |=> irq_ready_pin_oe
      == ($past(reg_wdata[6]) | $past(reg_wdata[0])))
    else $error("pin drive enable wrong");
  chk_pulse_single: assert property (
    set_pulse |=> !set_pulse)
    else $error("set pulse longer than one cycle");
  chk_cfg_readback: assert property (
    wr_to(7'h61) ##1 !reg_wr ##1 rd_of(7'h61)
      |=> reg_rdata == ($past(reg_wdata, 3) & 8'h1F))
    else $error("filter config readback wrong");
  chk_overflow_clear: assert property (
    rd_of(7'h64) ##1 (!reg_rd && !sample_valid) ##1 rd_of(7'h64)
      |=> !reg_rdata[1])
    else $error("overflow flag not cleared by read");
endmodule : mag_irq_props

bind mag_config_threshold_irq mag_irq_props u_props (
  .sys_clk, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_from_two_wire, .reg_rdata, .sample_valid, .set_pulse,
  .offset_cancel_en, .lowpass_en, .filter_bw_div_log2,
  .two_wire_disable, .byte_swap_en, .irq_ready_pin_oe
);

`default_nettype wire

// >>> tb/mag_host_model.sv
`timescale 1ns/100ps
`default_nettype none

module mag_host_model (
  // Clock
  input  wire logic       sys_clk,
  // Register port
  output logic [6:0]      reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_wdata,
  output logic            reg_from_two_wire,
  input  wire logic [7:0] reg_rdata
);
  int idle_cycles = 0;

  initial begin
    reg_addr = 7'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    reg_from_two_wire = 1'b0;
  end

  // Callers pass reserved bits as zero
  task automatic wr(input logic [6:0] a, input logic [7:0] d,
                    input logic tw);
    repeat (idle_cycles) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_from_two_wire <= tw;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
    @(negedge sys_clk);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic tw,
                    output logic [7:0] d);
    repeat (idle_cycles) @(posedge sys_clk);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_from_two_wire <= tw;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : rd
endmodule : mag_host_model

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import mag_irq_pkg::*;
  logic        sys_clk, reset_n, reg_wr, reg_rd, reg_from_two_wire;
  logic [6:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, rdv;
  logic        out_word_read_busy, sample_valid, data_ready_clear;
  axis_word_t  x_raw, y_raw, z_raw, x_hard_iron, y_hard_iron, z_hard_iron;
  logic        set_pulse, offset_cancel_en, single_meas_offset_cancel_en;
  logic        lowpass_en, self_test_en, two_wire_disable, block_update_en;
  logic        byte_swap_en, all_axes_new_data, irq_ready_pin;
  logic        irq_ready_pin_oe;
  logic [1:0]  filter_bw_div_log2;
  logic [15:0] x_out_word, y_out_word, z_out_word;
  int          miscompares, total_checks, pulses;

  mag_host_model u_host (.sys_clk, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_from_two_wire, .reg_rdata);

  mag_config_threshold_irq u_dut (.sys_clk, .reset_n, .reg_addr, .reg_wr,
    .reg_rd, .reg_wdata, .reg_from_two_wire, .reg_rdata,
    .out_word_read_busy, .sample_valid, .output_sample_rate(RATE_10HZ),
    .x_raw, .y_raw, .z_raw, .x_hard_iron, .y_hard_iron,
    .z_hard_iron, .data_ready_clear, .set_pulse,
    .offset_cancel_en, .single_meas_offset_cancel_en, .lowpass_en,
    .filter_bw_div_log2, .self_test_en, .two_wire_disable,
    .block_update_en, .byte_swap_en, .x_out_word, .y_out_word,
    .z_out_word, .all_axes_new_data, .irq_ready_pin, .irq_ready_pin_oe);

  // ----------------------------------------
  // Clock, pulse count, watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (set_pulse === 1'b1) pulses++;
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string n, input logic [15:0] e,
                       input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : check
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    u_host.rd(a, 1'b0, rdv);
    check($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdv});
  endtask : rdchk
  task automatic smp(input axis_word_t x, input axis_word_t y,
                     input axis_word_t z);
    @(posedge sys_clk);
    x_raw <= x;
    y_raw <= y;
    z_raw <= z;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    @(negedge sys_clk);
  endtask : smp
  task automatic irq(input logic [7:0] c, input axis_word_t x,
                     input axis_word_t y, input axis_word_t z,
                     input logic [7:0] e);
    u_host.wr(7'h63, c, 1'b0);
    smp(x, y, z);
    rdchk(7'h64, e);
  endtask : irq
  task automatic clear_ready();
    @(posedge sys_clk);
    data_ready_clear <= 1'b1;
    @(posedge sys_clk);
    data_ready_clear <= 1'b0;
    @(negedge sys_clk);
  endtask : clear_ready
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    reset_n = 1'b0;
    {out_word_read_busy, sample_valid, data_ready_clear} = 3'h0;
    {x_raw, y_raw, z_raw, x_hard_iron, y_hard_iron, z_hard_iron} = '0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(7'h61, 8'h00);
    rdchk(7'h62, 8'h00);
    rdchk(7'h63, 8'hE0);
    rdchk(7'h65, 8'h00);
    check("new data", 16'h0, 16'(all_axes_new_data));
    check("power-on pulse", 16'h1, 16'(pulses));
    repeat (63) smp(16'sh0, 16'sh0, 16'sh0);
    repeat (2) @(posedge sys_clk);
    check("periodic pulse", 16'h2, 16'(pulses));
    u_host.wr(7'h61, 8'h04, 1'b0);
    repeat (63) smp(16'sh0, 16'sh0, 16'sh0);
    repeat (2) @(posedge sys_clk);
    check("no periodic pulse", 16'h2, 16'(pulses));
    u_host.wr(7'h61, 8'h1B, 1'b0);
    check("filter bits", 16'h1E, 16'({single_meas_offset_cancel_en,
      offset_cancel_en, lowpass_en, filter_bw_div_log2}));
    rdchk(7'h61, 8'h1B);
    u_host.wr(7'h62, 8'h3A, 1'b0);
    check("pin bits", 16'hF, 16'({two_wire_disable, block_update_en,
      byte_swap_en, self_test_en}));
    u_host.wr(7'h61, 8'h00, 1'b1);
    check("lowpass", 16'h1, 16'(lowpass_en));
    u_host.wr(7'h61, 8'h00, 1'b0);
    check("bandwidth", 16'h1, 16'(filter_bw_div_log2));
    u_host.wr(7'h62, 8'h08, 1'b0);
    smp(16'sh1234, 16'sh0, 16'sh0);
    check("swapped word", 16'h3412, x_out_word);
    u_host.wr(7'h62, 8'h10, 1'b0);
    out_word_read_busy <= 1'b1;
    smp(16'sh5678, 16'sh0, 16'sh0);
    check("held word", 16'h1234, x_out_word);
    out_word_read_busy <= 1'b0;
    smp(16'sh5678, 16'sh0, 16'sh0);
    check("new word", 16'h5678, x_out_word);
    u_host.wr(7'h65, 8'h10, 1'b0);
    u_host.wr(7'h66, 8'h01, 1'b0);
    rdchk(7'h66, 8'h01);
    irq(8'hE1, 16'sh0110, 16'sh0111, -16'sh0111, 8'h44);
    irq(8'hE1, -16'sh0110, -16'sh0111, 16'sh0, 8'h08);
    irq(8'h61, 16'sh7000, 16'sh0, 16'sh0, 8'h01);
    irq(8'hE0, 16'sh7000, 16'sh0, 16'sh0, 8'h01);
    u_host.wr(7'h62, 8'h40, 1'b0);
    irq(8'hE5, 16'sh7000, 16'sh0, 16'sh0, 8'h81);
    check("pin raised", 16'h3,
      16'({irq_ready_pin, irq_ready_pin_oe}));
    smp(16'sh0, 16'sh0, 16'sh0);
    check("pin dropped", 16'h0, 16'(irq_ready_pin));
    u_host.wr(7'h63, 8'hE3, 1'b0);
    smp(16'sh7000, 16'sh0, 16'sh0);
    smp(16'sh0, 16'sh0, 16'sh0);
    rdchk(7'h64, 8'h80);
    rdchk(7'h64, 8'h01);
    x_hard_iron <= 16'sh0100;
    irq(8'hE1, 16'sh0200, 16'sh0, 16'sh0, 8'h80);
    u_host.wr(7'h61, 8'h08, 1'b0);
    irq(8'hE1, 16'sh0200, 16'sh0, 16'sh0, 8'h01);
    x_hard_iron <= 16'sh0001;
    irq(8'hE0, 16'sh8000, 16'sh0, 16'sh0, 8'h03);
    rdchk(7'h64, 8'h01);
    x_hard_iron <= 16'sh0000;
    y_hard_iron <= 16'sh0010;
    z_hard_iron <= -16'sh0010;
    u_host.wr(7'h62, 8'h01, 1'b0);
    smp(16'sh0, 16'sh0100, 16'sh0100);
    check("ready pin", 16'h7, 16'({irq_ready_pin, irq_ready_pin_oe,
      all_axes_new_data}));
    check("y word", 16'h00F0, y_out_word);
    check("z word", 16'h0110, z_out_word);
    clear_ready();
    check("ready cleared", 16'h0, 16'(irq_ready_pin));
    u_host.wr(7'h62, 8'h41, 1'b0);
    irq(8'hE1, 16'sh7000, 16'sh0, 16'sh0, 8'h80);
    clear_ready();
    check("shared pin", 16'h1, 16'(irq_ready_pin));
    u_host.idle_cycles = 4;
    rdchk(7'h63, 8'hE1);
    u_host.idle_cycles = 0;
    @(posedge sys_clk);
    reset_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rdchk(7'h62, 8'h00);
    check("reset pulse", 16'h3, 16'(pulses));
    final_report();
  end
endmodule : tb_top

`default_nettype wire
